// >>> logic/power_control_inputs.sv
`include "pwr_ctl_map.svh"
`timescale 1ns/10ps
`default_nettype none

module power_control_inputs #(
    parameter int PINS = 6,
    parameter int CYCLES_PER_MS = `MS_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wholeChipEnable,
    input wire logic powerRequestInput,
    input wire logic nvmReady,
    input wire logic sequencerFault,
    input wire logic softwareReset,
    input wire logic coldReset,
    input wire logic railsGood,
    input wire logic slowClockIn,
    input wire logic [PINS-1:0] pinIn,
    output logic [PINS-1:0] pinOut,
    output logic [PINS-1:0] pinOe,
    input wire pwr_ctl_pkg::reg_req_t regReq,
    output logic [7:0] rdData,
    output logic regulatorEnable,
    output pwr_ctl_pkg::seq_state_t seqState,
    output logic sleepRequest,
    output logic watchdogKick,
    output logic coldResetRequest
);
    import pwr_ctl_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [PINS-1:0] pinMeta;
    logic [PINS-1:0] pinSync;
    logic enableMeta, enableSync, reqMeta, reqSync;

    // Pins are asynchronous; second stage is the only reader of the first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinMeta <= '0;
            pinSync <= '0;
            enableMeta <= 1'b0;
            enableSync <= 1'b0;
            reqMeta <= 1'b0;
            reqSync <= 1'b0;
        end else if (ce) begin
            pinMeta <= pinIn;
            pinSync <= pinMeta;
            enableMeta <= wholeChipEnable;
            enableSync <= enableMeta;
            reqMeta <= powerRequestInput;
            reqSync <= reqMeta;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [PINS-1:0][7:0] pinSetup;
    logic [PINS-1:0][6:0] onDelay;
    logic [PINS-1:0][6:0] offDelay;
    logic [PINS-1:0] outValueReg;
    logic lockReg;
    logic [3:0] reqCtlReg;
    logic [7:0] shutdownHoldReg;
    seq_state_t stateReg;
    logic setupHit;

    assign setupHit = regReq.addr >= `PIN_SETUP_FIRST && regReq.addr <= `PIN_SETUP_LAST;

    // Software writes; lock is sticky so a stray write cannot undo it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < PINS; i++) begin
                pinSetup[i] <= `PIN_SETUP_RESET;
                onDelay[i] <= `PIN_DELAY_RESET;
                offDelay[i] <= `PIN_DELAY_RESET;
            end
            outValueReg <= '0;
            lockReg <= 1'b0;
            reqCtlReg <= `REQ_CTL_RESET;
            shutdownHoldReg <= `SHUTDOWN_HOLD_RESET;
        end else if (ce && regReq.write) begin
            for (int i = 0; i < PINS; i++) begin
                if (setupHit && !lockReg && regReq.addr == 8'(`PIN_SETUP_FIRST + i)) begin
                    pinSetup[i] <= regReq.wdata;
                end
                if (regReq.addr == 8'(`PIN_ON_DELAY_BASE + i)) begin
                    onDelay[i] <= regReq.wdata[6:0];
                end
                if (regReq.addr == 8'(`PIN_OFF_DELAY_BASE + i)) begin
                    offDelay[i] <= regReq.wdata[6:0];
                end
            end
            if (regReq.addr == `PIN_OUTPUT_VALUE) begin
                outValueReg <= regReq.wdata[PINS-1:0];
            end
            if (regReq.addr == `PIN_SETUP_LOCK && regReq.wdata[0]) begin
                lockReg <= 1'b1;
            end
            if (regReq.addr == `REQUEST_CONTROL) begin
                reqCtlReg <= regReq.wdata[3:0];
            end
            if (regReq.addr == `SHUTDOWN_HOLD) begin
                shutdownHoldReg <= regReq.wdata;
            end
        end
    end

    // Read mux; unmapped offsets answer zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= 8'h00;
        end else if (ce && regReq.read) begin
            rdData <= 8'h00;
            for (int i = 0; i < PINS; i++) begin
                if (regReq.addr == 8'(`PIN_SETUP_FIRST + i)) begin
                    rdData <= pinSetup[i];
                end
                if (regReq.addr == 8'(`PIN_ON_DELAY_BASE + i)) begin
                    rdData <= {1'b0, onDelay[i]};
                end
                if (regReq.addr == 8'(`PIN_OFF_DELAY_BASE + i)) begin
                    rdData <= {1'b0, offDelay[i]};
                end
            end
            case (regReq.addr)
                `PIN_OUTPUT_VALUE: rdData <= 8'(outValueReg);
                `PIN_INPUT_LEVEL: rdData <= 8'(pinSync);
                `PIN_SETUP_LOCK: rdData <= {7'h00, lockReg};
                `REQUEST_CONTROL: rdData <= {4'h0, reqCtlReg};
                `SHUTDOWN_HOLD: rdData <= shutdownHoldReg;
                `SEQUENCER_STATUS: rdData <= {5'h00, stateReg};
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Millisecond tick
    // ----------------------------------------
    logic [15:0] msCnt;
    logic msTick;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            msCnt <= 16'h0000;
            msTick <= 1'b0;
        end else if (ce) begin
            msTick <= msCnt == 16'(CYCLES_PER_MS - 1);
            msCnt <= (msCnt == 16'(CYCLES_PER_MS - 1)) ? 16'h0000 : msCnt + 16'h0001;
        end
    end

    // ----------------------------------------
    // Power request input: switch or push-button
    // ----------------------------------------
    logic pressActive, buttonMode, reqInternal, armed;
    logic [11:0] holdMs, holdTarget;

    assign buttonMode = reqCtlReg[`REQ_CTL_BUTTON_BIT];
    assign pressActive = reqSync ^ reqCtlReg[`REQ_CTL_INVERT_BIT];

    always_comb begin
        case (reqCtlReg[`REQ_CTL_HOLD_LSB +: 2])
            2'h0: holdTarget = `HOLD_1000_MS;
            2'h1: holdTarget = `HOLD_1500_MS;
            2'h2: holdTarget = `HOLD_2000_MS;
            default: holdTarget = `HOLD_3000_MS;
        endcase
    end

    // A press toggles the request once; the button must be let go before the next counts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reqInternal <= 1'b0;
            holdMs <= 12'h000;
            armed <= 1'b1;
        end else if (ce) begin
            if (!buttonMode) begin
                reqInternal <= pressActive;
                holdMs <= 12'h000;
                armed <= 1'b1;
            end else if (!pressActive) begin
                holdMs <= 12'h000;
                armed <= 1'b1;
            end else if (armed && msTick) begin
                if (holdMs + 12'h001 >= holdTarget) begin
                    reqInternal <= !reqInternal;
                    holdMs <= 12'h000;
                    armed <= 1'b0;
                end else begin
                    holdMs <= holdMs + 12'h001;
                end
            end
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic seqRequest, seqPause, causeEnable;
    logic [6:0] seqMs;
    logic [7:0] waitMs;
    logic [11:0] leaveCnt;
    pin_setup_t setup [PINS];

    assign seqRequest = enableSync && reqInternal && !sequencerFault && !softwareReset && !coldReset;

    // A late power-good pin freezes the shared timer, so outputs with larger
    // delays slip by the largest lateness while earlier ones are already done
    always_comb begin
        seqPause = 1'b0;
        for (int i = 0; i < PINS; i++) begin
            setup[i] = pin_setup_t'(pinSetup[i]);
            if (setup[i].fn == FN_PGOOD_IN) begin
                if (stateReg == ST_POWER_UP && seqMs >= onDelay[i] && !(pinSync[i] ^ setup[i].invert)) begin
                    seqPause = 1'b1;
                end
                if (stateReg == ST_POWER_DOWN && seqMs >= offDelay[i] && (pinSync[i] ^ setup[i].invert)) begin
                    seqPause = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stateReg <= ST_RESET;
            seqMs <= 7'h00;
            waitMs <= 8'h00;
            leaveCnt <= 12'h000;
            causeEnable <= 1'b0;
        end else if (ce) begin
            case (stateReg)
                ST_RESET: begin
                    if (enableSync && nvmReady) begin
                        stateReg <= ST_STANDBY;
                    end
                end
                ST_STANDBY: begin
                    if (!enableSync) begin
                        stateReg <= ST_RESET;
                    end else if (seqRequest) begin
                        stateReg <= ST_STANDBY_LEAVE;
                        leaveCnt <= 12'h000;
                    end
                end
                ST_STANDBY_LEAVE: begin
                    if (!seqRequest) begin
                        stateReg <= ST_STANDBY;
                    end else if (leaveCnt == 12'(`LEAVE_CYCLES - 1)) begin
                        stateReg <= ST_POWER_UP;
                        seqMs <= 7'h00;
                    end else begin
                        leaveCnt <= leaveCnt + 12'h001;
                    end
                end
                ST_POWER_UP, ST_ACTIVE: begin
                    if (!seqRequest) begin
                        stateReg <= ST_POWER_DOWN;
                        seqMs <= 7'h00;
                        causeEnable <= !enableSync;
                    end else if (stateReg == ST_POWER_UP && seqMs == `SEQ_FULL_MS) begin
                        stateReg <= ST_ACTIVE;
                    end else if (stateReg == ST_POWER_UP && msTick && !seqPause) begin
                        seqMs <= seqMs + 7'h01;
                    end
                end
                ST_POWER_DOWN: begin
                    if (causeEnable && seqRequest) begin
                        stateReg <= ST_POWER_UP;
                        seqMs <= 7'h00;
                    end else if (seqMs == `SEQ_FULL_MS) begin
                        // An enable pulse that is already over by now is ignored unless it started the power-down
                        if (causeEnable || !enableSync) begin
                            stateReg <= ST_SHUTDOWN_WAIT;
                            waitMs <= 8'h00;
                        end else begin
                            stateReg <= ST_STANDBY;
                        end
                    end else if (msTick && !seqPause) begin
                        seqMs <= seqMs + 7'h01;
                    end
                end
                ST_SHUTDOWN_WAIT: begin
                    if (waitMs >= shutdownHoldReg) begin
                        stateReg <= ST_STANDBY;
                    end else if (msTick) begin
                        waitMs <= waitMs + 8'h01;
                    end
                end
                default: stateReg <= ST_RESET;
            endcase
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    logic pinsLive;

    assign pinsLive = !(stateReg == ST_RESET && !enableSync);

    for (genvar g = 0; g < PINS; g++) begin : gPin
        logic asserted, isOutput, level, rstOn, vrOn;

        // Sequenced levels of reset and regulator-enable outputs
        always_comb begin
            case (stateReg)
                ST_POWER_UP: begin
                    rstOn = seqMs < onDelay[g];
                    vrOn = seqMs >= onDelay[g];
                end
                ST_ACTIVE: begin
                    rstOn = 1'b0;
                    vrOn = 1'b1;
                end
                ST_POWER_DOWN: begin
                    rstOn = seqMs >= offDelay[g];
                    vrOn = seqMs < offDelay[g];
                end
                default: begin
                    rstOn = 1'b1;
                    vrOn = 1'b0;
                end
            endcase
        end

        // Function select; the clock output exists on the third pin only
        always_comb begin
            isOutput = 1'b1;
            case (setup[g].fn)
                FN_RESET_OUT: asserted = rstOn;
                FN_VR_EN_OUT: asserted = vrOn;
                FN_GP_OUT: asserted = outValueReg[g];
                FN_PGOOD_OUT: asserted = railsGood;
                FN_SLOW_CLOCK: begin
                    asserted = slowClockIn;
                    isOutput = g == 2;
                end
                default: begin
                    asserted = 1'b0;
                    isOutput = 1'b0;
                end
            endcase
            level = asserted ^ setup[g].invert;
        end

        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                pinOut[g] <= 1'b0;
                pinOe[g] <= 1'b0;
            end else if (ce) begin
                pinOut[g] <= level;
                case (setup[g].drive)
                    DRV_PULL_DOWN: pinOe[g] <= pinsLive && isOutput && !level;
                    DRV_PULL_UP: pinOe[g] <= pinsLive && isOutput && level;
                    DRV_PUSH_PULL: pinOe[g] <= pinsLive && isOutput;
                    default: pinOe[g] <= 1'b0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Status outputs and dedicated inputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regulatorEnable <= 1'b0;
            seqState <= ST_RESET;
            sleepRequest <= 1'b0;
            watchdogKick <= 1'b0;
            coldResetRequest <= 1'b0;
        end else if (ce) begin
            regulatorEnable <= stateReg == ST_POWER_UP || stateReg == ST_ACTIVE;
            seqState <= stateReg;
            sleepRequest <= setup[3].fn == FN_SLEEP_IN && (pinSync[3] ^ setup[3].invert);
            watchdogKick <= setup[4].fn == FN_WATCHDOG_IN && (pinSync[4] ^ setup[4].invert);
            coldResetRequest <= setup[5].fn == FN_COLD_RESET_IN && (pinSync[5] ^ setup[5].invert);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    tristate_off_a: assert property (ce && stateReg == ST_RESET && !enableSync |=> pinOe == '0)
        else $error("pins driven while disabled");
    enable_drop_a: assert property (ce && stateReg == ST_ACTIVE && !enableSync |=> stateReg == ST_POWER_DOWN)
        else $error("enable drop did not start power-down");
    restart_up_a: assert property (ce && stateReg == ST_POWER_DOWN && causeEnable && seqRequest
        |=> stateReg == ST_POWER_UP && seqMs == 7'h00)
        else $error("power-up not restarted");
    shutdown_hold_a: assert property (ce && stateReg == ST_SHUTDOWN_WAIT && waitMs < shutdownHoldReg
        |=> stateReg == ST_SHUTDOWN_WAIT)
        else $error("shutdown wait cut short");
    ignore_pulse_a: assert property (ce && stateReg == ST_POWER_DOWN && !causeEnable && seqMs != `SEQ_FULL_MS
        |=> stateReg == ST_POWER_DOWN)
        else $error("power-down left early");
    hold_time_a: assert property (ce && buttonMode && $changed(reqInternal) && $past(buttonMode)
        |-> $past(holdMs) + 12'h001 >= holdTarget)
        else $error("button request without full hold");
    leave_path_a: assert property (ce && stateReg == ST_STANDBY && enableSync && seqRequest
        |=> stateReg == ST_STANDBY_LEAVE)
        else $error("standby did not leave on request");
    timer_freeze_a: assert property (ce && seqPause && stateReg == ST_POWER_UP && seqRequest
        && seqMs != `SEQ_FULL_MS |=> seqMs == $past(seqMs))
        else $error("timer ran while power-good late");
    setup_lock_a: assert property (ce && lockReg && regReq.write && setupHit |=> pinSetup == $past(pinSetup))
        else $error("locked setup changed");
    request_gate_a: assert property (stateReg == ST_ACTIVE && ce && (sequencerFault || coldReset)
        |=> stateReg == ST_POWER_DOWN)
        else $error("fault did not drop request");

endmodule // power_control_inputs

`default_nettype wire

// >>> logic/pwr_ctl_map.svh
`ifndef PWR_CTL_MAP_SVH
`define PWR_CTL_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PIN_SETUP_FIRST 8'h8a
`define PIN_SETUP_LAST 8'h8f
`define PIN_ON_DELAY_BASE 8'h90
`define PIN_OFF_DELAY_BASE 8'h96
`define PIN_OUTPUT_VALUE 8'h9c
`define PIN_INPUT_LEVEL 8'h9d
`define PIN_SETUP_LOCK 8'h9e
`define REQUEST_CONTROL 8'h9f
`define SHUTDOWN_HOLD 8'ha0
`define SEQUENCER_STATUS 8'ha1

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define REQ_CTL_BUTTON_BIT 0
`define REQ_CTL_INVERT_BIT 1
`define REQ_CTL_HOLD_LSB 2
`define PIN_SETUP_RESET 8'h00
`define PIN_DELAY_RESET 7'h00
`define REQ_CTL_RESET 4'h0
`define SHUTDOWN_HOLD_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 25000000
`define MS_CYCLES (`CLK_HZ / 1000)
`define LEAVE_TIME_US 80
`define LEAVE_CYCLES ((`CLK_HZ / 1000000) * `LEAVE_TIME_US)
`define HOLD_1000_MS 12'd1000
`define HOLD_1500_MS 12'd1500
`define HOLD_2000_MS 12'd2000
`define HOLD_3000_MS 12'd3000
`define SEQ_FULL_MS 7'h7f

`endif

// >>> logic/pwr_ctl_pkg.sv
`default_nettype none

package pwr_ctl_pkg;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_STANDBY = 3'b001,
        ST_STANDBY_LEAVE = 3'b010,
        ST_POWER_UP = 3'b011,
        ST_ACTIVE = 3'b100,
        ST_POWER_DOWN = 3'b101,
        ST_SHUTDOWN_WAIT = 3'b110
    } seq_state_t;

    typedef enum logic [3:0] {
        FN_DISABLED = 4'h0,
        FN_PGOOD_IN = 4'h1,
        FN_GP_IN = 4'h2,
        FN_PGOOD_OUT = 4'h3,
        FN_RESET_OUT = 4'h4,
        FN_VR_EN_OUT = 4'h5,
        FN_GP_OUT = 4'h6,
        FN_SLOW_CLOCK = 4'h7,
        FN_SLEEP_IN = 4'h8,
        FN_WATCHDOG_IN = 4'h9,
        FN_COLD_RESET_IN = 4'ha
    } pin_fn_t;

    typedef enum logic [1:0] {
        DRV_HIGH_Z = 2'h0,
        DRV_PULL_DOWN = 2'h1,
        DRV_PULL_UP = 2'h2,
        DRV_PUSH_PULL = 2'h3
    } pin_drive_t;

    typedef struct packed {
        logic reserved;
        pin_fn_t fn;
        logic invert;
        pin_drive_t drive;
    } pin_setup_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

`default_nettype wire

// >>> testbench/host_pins.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------
// Host side of the control pins
// ----------------------------------
module host_pins (
    input wire logic clk,
    input wire logic enCmd,
    input wire logic reqCmd,
    input wire logic actLow,
    input wire logic [5:0] lvlCmd,
    input wire logic [15:0] pgDelay,
    input wire logic [5:0] pinOut,
    input wire logic [5:0] pinOe,
    output logic wholeChipEnable,
    output logic powerRequestInput,
    output logic [5:0] pinIn
);
    logic [15:0] cnt_reg;
    logic pgood_reg;
    logic last_reg;
    // Known levels from time zero
    initial begin
        {wholeChipEnable, powerRequestInput, pgood_reg, last_reg} = 4'h0;
        cnt_reg = 16'h0000;
    end
    // Pins move just after the edge; press length is set by the caller
    always @(posedge clk) begin
        wholeChipEnable <= enCmd;
        powerRequestInput <= reqCmd ^ actLow;
        last_reg <= reqCmd & enCmd;
        if (last_reg != (reqCmd & enCmd))
            cnt_reg <= 16'h0000;
        else if (cnt_reg != 16'hffff)
            cnt_reg <= cnt_reg + 16'h0001;
        // Power-good on pin 2 follows request and enable pgDelay cycles later, so it can be made late
        if (cnt_reg >= pgDelay)
            pgood_reg <= last_reg;
    end
    // The device wins the wire wherever it drives
    assign pinIn = (pinOe & pinOut) | (~pinOe & {lvlCmd[5:3], pgood_reg, lvlCmd[1:0]});
endmodule // host_pins
`default_nettype wire

// >>> testbench/power_control_inputs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module power_control_inputs_tb;
    import pwr_ctl_pkg::*;
    logic clk, rst_b, enCmd, reqCmd, actLow, fault, swReset, cold, wce, pri, regEn;
    logic sleepReq, wdKick, coldReq;
    logic [5:0] lvlCmd, pinIn, pinOut, pinOe;
    logic [15:0] pgDelay;
    logic [7:0] rdData;
    reg_req_t regReq;
    seq_state_t seqState;
    int n_errors, checked;

    host_pins partner (.clk(clk), .enCmd(enCmd), .reqCmd(reqCmd), .actLow(actLow), .lvlCmd(lvlCmd),
        .pgDelay(pgDelay), .pinOut(pinOut), .pinOe(pinOe), .wholeChipEnable(wce),
        .powerRequestInput(pri), .pinIn(pinIn));
    // Four cycles per ms keeps the 127 ms sequence short
    power_control_inputs #(.CYCLES_PER_MS(4)) dut (.clk(clk), .rst_b(rst_b), .ce(1'b1),
        .wholeChipEnable(wce), .powerRequestInput(pri), .nvmReady(1'b1), .sequencerFault(fault),
        .softwareReset(swReset), .coldReset(cold), .railsGood(1'b0), .slowClockIn(1'b0),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .regReq(regReq), .rdData(rdData),
        .regulatorEnable(regEn), .seqState(seqState), .sleepRequest(sleepReq), .watchdogKick(wdKick),
        .coldResetRequest(coldReq));

    // ----------------------------------
    // Shared tasks
    // ----------------------------------
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk) regReq <= '{1'b1, 1'b0, a, d};
        @(posedge clk) regReq <= '0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk) regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) regReq <= '0;
        @(negedge clk) chk("read data", exp, rdData);
    endtask
    task automatic waitSt(seq_state_t s, int lim);
        for (int k = 0; k < lim && seqState !== s; k++)
            @(negedge clk);
        chk("state", 8'(s), 8'(seqState));
    endtask
    task automatic pin0(logic o, logic e);
        repeat (4) @(negedge clk);
        chk("pin0 level", {7'h00, o}, {7'h00, pinOut[0]});
        chk("pin0 enable", {7'h00, e}, {7'h00, pinOe[0]});
    endtask
    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------
    // Scenarios
    // ----------------------------------
    task automatic t_regs;
        waitSt(ST_STANDBY, 20);
        rd(8'hff, 8'h00);
        rd(8'h8a, 8'h00);
    endtask
    task automatic t_pins;
        wr(8'h8a, 8'h33);
        wr(8'h9c, 8'h01);
        pin0(1'b1, 1'b1);
        wr(8'h8a, 8'h37);
        pin0(1'b0, 1'b1);
        wr(8'h8a, 8'h31);
        pin0(1'b1, 1'b0);
        wr(8'h9c, 8'h00);
        pin0(1'b0, 1'b1);
        wr(8'h8a, 8'h32);
        pin0(1'b0, 1'b0);
        wr(8'h8a, 8'h03);
        pin0(1'b0, 1'b0);
        wr(8'h8b, 8'h10);
        @(posedge clk) lvlCmd <= 6'h02;
        repeat (4) @(posedge clk);
        rd(8'h9d, 8'h02);
        // Slow clock is refused on pin 0; pins 3 to 5 take their dedicated inputs
        wr(8'h8a, 8'h3b);
        pin0(1'b0, 1'b0);
        wr(8'h8d, 8'h40);
        wr(8'h8e, 8'h48);
        wr(8'h8f, 8'h50);
        @(posedge clk) lvlCmd <= 6'h3a;
        repeat (4) @(negedge clk);
        chk("dedicated inputs", 8'h07, {5'h00, sleepReq, wdKick, coldReq});
    endtask
    // Pin 0 enables a regulator at 1 ms; pin 2 power-good arrives late both ways
    task automatic t_pgood;
        wr(8'h8a, 8'h2b);
        wr(8'h8c, 8'h08);
        wr(8'h90, 8'h01);
        @(posedge clk) pgDelay <= 16'd2200;
        reqCmd <= 1'b1;
        waitSt(ST_STANDBY_LEAVE, 10);
        waitSt(ST_POWER_UP, 2100);
        chk("regulator enable", 8'h01, {7'h00, regEn});
        repeat (36) @(negedge clk);
        pin0(1'b0, 1'b1);
        for (int k = 0; k < 400 && pinOut[0] !== 1'b1; k++)
            @(negedge clk);
        pin0(1'b1, 1'b1);
        waitSt(ST_ACTIVE, 600);
        // Cold reset in the active state drops the request along with the pin
        @(posedge clk) {reqCmd, cold} <= 2'b01;
        waitSt(ST_POWER_DOWN, 10);
        repeat (1000) @(negedge clk);
        chk("paused state", 8'(ST_POWER_DOWN), 8'(seqState));
        pin0(1'b0, 1'b1);
        waitSt(ST_STANDBY, 2000);
    endtask
    task automatic t_enable;
        wr(8'ha0, 8'h02);
        @(posedge clk) pgDelay <= 16'd1;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) {fault, swReset, cold} <= 3'b100 >> i;
            reqCmd <= 1'b1;
            repeat (100) @(negedge clk);
            chk("blocked state", 8'(ST_STANDBY), 8'(seqState));
        end
        @(posedge clk) {fault, swReset, cold} <= 3'b000;
        waitSt(ST_ACTIVE, 3000);
        // Enable back before power-down ends goes straight to power-up
        @(posedge clk) enCmd <= 1'b0;
        waitSt(ST_POWER_DOWN, 10);
        @(posedge clk) enCmd <= 1'b1;
        waitSt(ST_POWER_UP, 10);
        waitSt(ST_ACTIVE, 600);
        @(posedge clk) enCmd <= 1'b0;
        waitSt(ST_POWER_DOWN, 10);
        waitSt(ST_SHUTDOWN_WAIT, 700);
        repeat (4) @(negedge clk);
        chk("hold state", 8'(ST_SHUTDOWN_WAIT), 8'(seqState));
        waitSt(ST_RESET, 20);
        chk("pins off", 8'h00, {2'b00, pinOe});
        @(posedge clk) enCmd <= 1'b1;
        reqCmd <= 1'b0;
        waitSt(ST_STANDBY, 20);
    endtask
    // Active-low push-button, 1 s hold; two short presses must not add up
    task automatic t_button;
        wr(8'h9f, 8'h03);
        @(posedge clk) actLow <= 1'b1;
        repeat (2) begin
            @(posedge clk) reqCmd <= 1'b1;
            repeat (3000) @(posedge clk);
            reqCmd <= 1'b0;
            repeat (10) @(negedge clk);
        end
        chk("short press", 8'(ST_STANDBY), 8'(seqState));
        @(posedge clk) reqCmd <= 1'b1;
        waitSt(ST_STANDBY_LEAVE, 4200);
        @(posedge clk) reqCmd <= 1'b0;
    endtask
    task automatic t_lock;
        wr(8'h9e, 8'h01);
        wr(8'h8a, 8'h00);
        rd(8'h8a, 8'h2b);
        rd(8'h9e, 8'h01);
    endtask

    // Free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Main sequence
    initial begin
        {rst_b, reqCmd, actLow, fault, swReset, cold} = 6'h00;
        enCmd = 1'b1;
        lvlCmd = 6'h00;
        pgDelay = 16'd1;
        regReq = '0;
        n_errors = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_regs;
        t_pins;
        t_pgood;
        t_enable;
        t_button;
        t_lock;
        final_report;
    end
    // Watchdog well beyond the expected 20k cycles
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        final_report;
    end
endmodule // power_control_inputs_tb
`default_nettype wire
